//--- src/cdg_map.svh
// Behaviour
// - dead-band tick from system or 16 MHz clock
// - two-bit field picks one of four inputs
// - enabling starts with both drives cleared
// - output enable gates each pin individually
// - module disabled releases both pins entirely
// - polarity bit set means active high
// - polarity never touches override levels
// - two independent 6-bit dead-band counters
// - count dead-band ticks from zero to value
// - rise kills B, delays A by rising count
// - fall kills A, delays B by falling count
// - zero dead band turns output on at once
// - short input pulse never turns output on
// - edge timing uncertain by one tick at most
// - writing shutdown bit forces override levels
// - without auto-restart shutdown holds while bit set
// - auto-restart clears bit, resumes at next rise
// - selected external shutdown input forces overrides
// - shutdown levels hold shutdown state while active
// - overrides drive A and B from own bits
// - keeps fast oscillator requested while running on the 16 MHz tick
// - software clear refused while shutdown input active
// - overrides hold until first rise after clear
// - auto-restart clears bit when sources low
`ifndef CDG_MAP_SVH
`define CDG_MAP_SVH

// register byte addresses
`define CDG_ADDR_CTRL0 12'h000
`define CDG_ADDR_CTRL1 12'h004
`define CDG_ADDR_SHUT 12'h008
`define CDG_ADDR_DBR 12'h00C
`define CDG_ADDR_DBF 12'h010
`define CDG_ADDR_STATUS 12'h014

// control_reg_0 fields
`define CDG_EN_BIT 7
`define CDG_OEB_BIT 6
`define CDG_OEA_BIT 5
`define CDG_POLB_BIT 4
`define CDG_POLA_BIT 3
`define CDG_CS_BIT 0

// control_reg_1 fields
`define CDG_LVLB_BIT 6
`define CDG_LVLA_BIT 5
`define CDG_IS_MSB 1
`define CDG_IS_LSB 0

// shutdown_control_reg fields
`define CDG_ASE_BIT 7
`define CDG_ARSEN_BIT 6
`define CDG_SDS_MSB 1
`define CDG_SDS_LSB 0

// reset values
`define CDG_CTRL_RST 8'h00
`define CDG_DB_RST 6'h00

// clock rates, fast oscillator made by fractional accumulation
`define CDG_SYS_CLK_MHZ 50
`define CDG_FAST_OSC_MHZ 16
`define CDG_ACC_W 7

`endif

//--- src/cdg_pkg.sv
package cdg_pkg;
    typedef enum logic [1:0] {
        CDG_SRC_CMP1,
        CDG_SRC_CMP2,
        CDG_SRC_PWM1,
        CDG_SRC_PWM2
    } cdg_source_t;

    typedef enum logic [1:0] {
        CDG_SDS_FAULT,
        CDG_SDS_CMP1_FAULT,
        CDG_SDS_CMP2_FAULT,
        CDG_SDS_CMP1_CMP2
    } cdg_shut_sel_t;
endpackage

//--- src/cdg_deadband.sv
module cdg_deadband import cdg_pkg::*; #(
    parameter int WIDTH = 6
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // control
    input wire logic clear,
    input wire logic tick,
    input wire logic start,
    input wire logic active,
    input wire logic [WIDTH-1:0] limit,
    // result
    output logic done
);
    logic [WIDTH-1:0] count_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_reg <= '0;
            done <= 1'b0;
        end else if (clear) begin
            count_reg <= '0;
            done <= 1'b0;
        end else if (start) begin
            count_reg <= '0;
            done <= (limit == '0);
        end else if (!active) begin
            count_reg <= '0;
            done <= 1'b0;
        end else if (tick && !done) begin
            count_reg <= count_reg + 1'b1;
            if (count_reg + 1'b1 == limit) begin
                done <= 1'b1;
            end
        end
    end
endmodule

//--- src/cdg_top.sv
`include "cdg_map.svh"

module cdg_top import cdg_pkg::*; #(
    parameter int DB_WIDTH = 6
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // waveform and shutdown sources
    input wire logic comparator1_out,
    input wire logic comparator2_out,
    input wire logic pwm1_out_a,
    input wire logic pwm2_out_b,
    input wire logic fault_pin_input,
    // output pins
    output logic output_a,
    output logic output_a_oe,
    output logic output_b,
    output logic output_b_oe,
    // clock request during sleep
    output logic fast_osc_request
);
    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic module_enable;
    logic output_a_enable;
    logic output_b_enable;
    logic output_a_polarity;
    logic output_b_polarity;
    logic deadband_clock_sel_bit;
    logic [1:0] input_source_select;
    logic override_level_a;
    logic override_level_b;
    logic shutdown_state;
    logic auto_restart_enable;
    logic [1:0] shutdown_source_sel;
    logic [DB_WIDTH-1:0] rising_deadband_count;
    logic [DB_WIDTH-1:0] falling_deadband_count;

    logic wr_en;
    logic rd_setup;
    logic addr_ok;
    logic sw_ase_set;
    logic sw_ase_clear;

    function automatic logic addr_valid_f(input logic [11:0] a);
        return a == `CDG_ADDR_CTRL0 || a == `CDG_ADDR_CTRL1 || a == `CDG_ADDR_SHUT ||
               a == `CDG_ADDR_DBR || a == `CDG_ADDR_DBF || a == `CDG_ADDR_STATUS;
    endfunction

    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign addr_ok = addr_valid_f(paddr);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign sw_ase_set = wr_en && paddr == `CDG_ADDR_SHUT && pwdata[`CDG_ASE_BIT];
    assign sw_ase_clear = wr_en && paddr == `CDG_ADDR_SHUT && !pwdata[`CDG_ASE_BIT];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            module_enable <= 1'b0;
            output_a_enable <= 1'b0;
            output_b_enable <= 1'b0;
            output_a_polarity <= 1'b0;
            output_b_polarity <= 1'b0;
            deadband_clock_sel_bit <= 1'b0;
        end else if (wr_en && paddr == `CDG_ADDR_CTRL0) begin
            module_enable <= pwdata[`CDG_EN_BIT];
            output_b_enable <= pwdata[`CDG_OEB_BIT];
            output_a_enable <= pwdata[`CDG_OEA_BIT];
            output_b_polarity <= pwdata[`CDG_POLB_BIT];
            output_a_polarity <= pwdata[`CDG_POLA_BIT];
            deadband_clock_sel_bit <= pwdata[`CDG_CS_BIT];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            input_source_select <= 2'h0;
            override_level_a <= 1'b0;
            override_level_b <= 1'b0;
        end else if (wr_en && paddr == `CDG_ADDR_CTRL1) begin
            input_source_select <= pwdata[`CDG_IS_MSB:`CDG_IS_LSB];
            override_level_b <= pwdata[`CDG_LVLB_BIT];
            override_level_a <= pwdata[`CDG_LVLA_BIT];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            auto_restart_enable <= 1'b0;
            shutdown_source_sel <= 2'h0;
        end else if (wr_en && paddr == `CDG_ADDR_SHUT) begin
            auto_restart_enable <= pwdata[`CDG_ARSEN_BIT];
            shutdown_source_sel <= pwdata[`CDG_SDS_MSB:`CDG_SDS_LSB];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rising_deadband_count <= `CDG_DB_RST;
            falling_deadband_count <= `CDG_DB_RST;
        end else if (wr_en && paddr == `CDG_ADDR_DBR) begin
            rising_deadband_count <= pwdata[DB_WIDTH-1:0];
        end else if (wr_en && paddr == `CDG_ADDR_DBF) begin
            falling_deadband_count <= pwdata[DB_WIDTH-1:0];
        end
    end

    // ------------------------------------------------------------
    // dead-band clock enable
    // ------------------------------------------------------------
    logic [`CDG_ACC_W-1:0] acc_reg;
    logic [`CDG_ACC_W-1:0] acc_sum;
    logic fast_tick;
    logic db_tick;

    assign acc_sum = acc_reg + `CDG_ACC_W'(`CDG_FAST_OSC_MHZ);
    assign fast_tick = acc_sum >= `CDG_ACC_W'(`CDG_SYS_CLK_MHZ);
    assign db_tick = deadband_clock_sel_bit ? fast_tick : 1'b1;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acc_reg <= '0;
        end else if (fast_tick) begin
            acc_reg <= acc_sum - `CDG_ACC_W'(`CDG_SYS_CLK_MHZ);
        end else begin
            acc_reg <= acc_sum;
        end
    end

    assign fast_osc_request = module_enable && deadband_clock_sel_bit;

    // ------------------------------------------------------------
    // source selection and edge detection
    // ------------------------------------------------------------
    logic src_level;
    logic in_reg;
    logic rise_edge;
    logic fall_edge;

    always_comb begin
        unique case (cdg_source_t'(input_source_select))
            CDG_SRC_CMP1: src_level = comparator1_out;
            CDG_SRC_CMP2: src_level = comparator2_out;
            CDG_SRC_PWM1: src_level = pwm1_out_a;
            CDG_SRC_PWM2: src_level = pwm2_out_b;
        endcase
    end

    // input sampled only on dead-band ticks, so delay jitters by one tick
    assign rise_edge = module_enable && db_tick && src_level && !in_reg;
    assign fall_edge = module_enable && db_tick && !src_level && in_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            in_reg <= 1'b0;
        end else if (!module_enable) begin
            in_reg <= 1'b0;
        end else if (db_tick) begin
            in_reg <= src_level;
        end
    end

    // ------------------------------------------------------------
    // dead-band counters
    // ------------------------------------------------------------
    logic rise_done;
    logic fall_done;
    logic wave_a;
    logic wave_b;

    cdg_deadband #(.WIDTH(DB_WIDTH)) u_rise_db (
        .clk(clk),
        .resetn(resetn),
        .clear(!module_enable),
        .tick(db_tick),
        .start(rise_edge),
        .active(in_reg),
        .limit(rising_deadband_count),
        .done(rise_done)
    );

    cdg_deadband #(.WIDTH(DB_WIDTH)) u_fall_db (
        .clk(clk),
        .resetn(resetn),
        .clear(!module_enable),
        .tick(db_tick),
        .start(fall_edge),
        .active(!in_reg),
        .limit(falling_deadband_count),
        .done(fall_done)
    );

    assign wave_a = in_reg && rise_done;
    assign wave_b = !in_reg && fall_done;

    // ------------------------------------------------------------
    // auto-shutdown
    // ------------------------------------------------------------
    logic shut_level;
    logic override_reg;

    function automatic logic shut_sel_f(input logic [1:0] sel, input logic c1, input logic c2,
                                        input logic flt);
        logic r;
        r = 1'b0;
        unique case (cdg_shut_sel_t'(sel))
            CDG_SDS_FAULT: r = flt;
            CDG_SDS_CMP1_FAULT: r = c1 || flt;
            CDG_SDS_CMP2_FAULT: r = c2 || flt;
            CDG_SDS_CMP1_CMP2: r = c1 || c2;
        endcase
        return r;
    endfunction

    assign shut_level = shut_sel_f(shutdown_source_sel, comparator1_out, comparator2_out,
                                   fault_pin_input);

    // setting by level or write wins over any clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shutdown_state <= 1'b0;
        end else if (shut_level) begin
            shutdown_state <= 1'b1;
        end else if (sw_ase_set) begin
            shutdown_state <= 1'b1;
        end else if (auto_restart_enable) begin
            shutdown_state <= 1'b0;
        end else if (sw_ase_clear) begin
            shutdown_state <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            override_reg <= 1'b0;
        end else if (shutdown_state || shut_level) begin
            override_reg <= 1'b1;
        end else if (rise_edge) begin
            override_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // output pins
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            output_a <= 1'b0;
            output_b <= 1'b0;
            output_a_oe <= 1'b0;
            output_b_oe <= 1'b0;
        end else begin
            output_a_oe <= module_enable && output_a_enable;
            output_b_oe <= module_enable && output_b_enable;
            if (!module_enable) begin
                output_a <= 1'b0;
                output_b <= 1'b0;
            end else if (override_reg || shut_level) begin
                output_a <= override_level_a;
                output_b <= override_level_b;
            end else begin
                output_a <= output_a_polarity ? wave_a : !wave_a;
                output_b <= output_b_polarity ? wave_b : !wave_b;
            end
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= 32'h0000_0000;
            unique case (paddr)
                `CDG_ADDR_CTRL0: begin
                    prdata[`CDG_EN_BIT] <= module_enable;
                    prdata[`CDG_OEB_BIT] <= output_b_enable;
                    prdata[`CDG_OEA_BIT] <= output_a_enable;
                    prdata[`CDG_POLB_BIT] <= output_b_polarity;
                    prdata[`CDG_POLA_BIT] <= output_a_polarity;
                    prdata[`CDG_CS_BIT] <= deadband_clock_sel_bit;
                end
                `CDG_ADDR_CTRL1: begin
                    prdata[`CDG_LVLB_BIT] <= override_level_b;
                    prdata[`CDG_LVLA_BIT] <= override_level_a;
                    prdata[`CDG_IS_MSB:`CDG_IS_LSB] <= input_source_select;
                end
                `CDG_ADDR_SHUT: begin
                    prdata[`CDG_ASE_BIT] <= shutdown_state;
                    prdata[`CDG_ARSEN_BIT] <= auto_restart_enable;
                    prdata[`CDG_SDS_MSB:`CDG_SDS_LSB] <= shutdown_source_sel;
                end
                `CDG_ADDR_DBR: prdata[DB_WIDTH-1:0] <= rising_deadband_count;
                `CDG_ADDR_DBF: prdata[DB_WIDTH-1:0] <= falling_deadband_count;
                `CDG_ADDR_STATUS: prdata[5:0] <= {shut_level, override_reg, in_reg, wave_b, wave_a, db_tick};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence rise_zero_s;
        rise_edge && rising_deadband_count == '0;
    endsequence

    sequence rise_delay_s;
        rise_edge && rising_deadband_count != '0;
    endsequence

    disabled_pins_a: assert property (!module_enable |=> !output_a_oe && !output_b_oe)
        else $error("pins driven while module disabled");
    enable_pin_a: assert property (module_enable && output_a_enable |=> output_a_oe)
        else $error("output a enable not applied");
    override_drive_a: assert property (override_reg && module_enable
                                       |=> output_a == $past(override_level_a))
        else $error("override level a not driven");
    no_overlap_a: assert property (!(wave_a && wave_b))
        else $error("both outputs active together");
    rise_kill_a: assert property (rise_delay_s |=> !wave_a && !wave_b)
        else $error("dead band skipped on rise");
    zero_band_a: assert property (rise_zero_s ##1 in_reg |-> wave_a)
        else $error("zero dead band delayed output a");
    fall_kill_a: assert property (fall_edge |=> !wave_a)
        else $error("output a not cut on fall");
    ext_shutdown_a: assert property (shut_level |=> shutdown_state ##1 override_reg)
        else $error("external shutdown not entered");
    hold_override_a: assert property ($fell(shutdown_state) |-> override_reg)
        else $error("override released before rising edge");
    enable_start_a: assert property ($rose(module_enable) |-> !wave_a && !wave_b)
        else $error("drives not cleared at enable");
    auto_clear_a: assert property (shutdown_state && auto_restart_enable && !shut_level && !sw_ase_set
                                   |=> !shutdown_state)
        else $error("auto-restart did not clear shutdown");
    fast_tick_a: assert property (db_tick && deadband_clock_sel_bit |=> !fast_tick ##1 !fast_tick)
        else $error("fast dead-band tick too frequent");
endmodule

//--- sim/cdg_gate_model.sv
module cdg_gate_model (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // pins from the block
    input wire logic output_a,
    input wire logic output_a_oe,
    input wire logic output_b,
    input wire logic output_b_oe,
    // gate levels seen by the drivers
    output logic gate_a,
    output logic gate_b,
    output logic shoot_through
);
    timeunit 1ns;
    timeprecision 1ps;

    // a released pin is pulled down, so its gate stays off
    assign gate_a = output_a_oe ? output_a : 1'b0;
    assign gate_b = output_b_oe ? output_b : 1'b0;

    // both switches on together would short the supply
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shoot_through <= 1'b0;
        end else if (gate_a && gate_b) begin
            shoot_through <= 1'b1;
        end
    end
endmodule

//--- sim/cdg_top_bench.sv
`include "cdg_map.svh"

module cdg_top_bench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [11:0] SD_MASK = 12'h7AC;
    logic clk, resetn, psel, penable, pwrite, pready, pslverr, perr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [4:0] drv;
    logic output_a, output_a_oe, output_b, output_b_oe, fast_osc_request;
    logic gate_a, gate_b, shoot_through;
    int n_mismatch, total_checks;
    // a slow dead-band tick may notice an input edge up to one tick late
    int off_max = 4;

    cdg_top #(.DB_WIDTH(6)) u_dut (
        .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .comparator1_out(drv[0]), .comparator2_out(drv[1]), .pwm1_out_a(drv[2]),
        .pwm2_out_b(drv[3]), .fault_pin_input(drv[4]),
        .output_a(output_a), .output_a_oe(output_a_oe), .output_b(output_b),
        .output_b_oe(output_b_oe), .fast_osc_request(fast_osc_request)
    );

    cdg_gate_model u_gate (
        .clk(clk), .resetn(resetn), .output_a(output_a), .output_a_oe(output_a_oe),
        .output_b(output_b), .output_b_oe(output_b_oe), .gate_a(gate_a), .gate_b(gate_b),
        .shoot_through(shoot_through)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic close_out;
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdv = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic pins(input logic a, input logic b);
        chk(output_a, a);
        chk(output_b, b);
    endtask

    // one input edge: the opposite output drops, the delayed one rises in [lo, hi]
    // an override level still high before the edge does not count as the rise
    task automatic edge_run(input logic lvl, input int lo, input int hi);
        int k;
        int off;
        int on;
        logic low_seen;
        off = 0;
        on = 0;
        low_seen = 1'b0;
        drv[2] <= lvl;
        for (k = 1; k <= 80; k++) begin
            @(posedge clk);
            if (off == 0 && (lvl ? output_b : output_a) === 1'b0) off = k;
            if (on == 0 && low_seen && (lvl ? output_a : output_b) === 1'b1) on = k;
            if ((lvl ? output_a : output_b) === 1'b0) low_seen = 1'b1;
        end
        chk(off >= 1 && off <= off_max, 1'b1);
        chk(on >= lo && on <= hi && on >= off, 1'b1);
    endtask

    task automatic short_pulse;
        logic seen;
        seen = 1'b0;
        drv[2] <= 1'b1;
        cyc(3);
        drv[2] <= 1'b0;
        repeat (20) begin
            @(posedge clk);
            if (output_a === 1'b1) seen = 1'b1;
        end
        chk(seen, 1'b0);
    endtask

    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        drv = 5'h00;
        cyc(20);
        resetn <= 1'b1;
        @(posedge clk);
        apb(`CDG_ADDR_CTRL0, 1'b0, 32'h0);
        chk(rdv, 32'h0);
        chk({output_a_oe, output_b_oe}, 2'b00);
        apb(12'h0FC, 1'b0, 32'h0);
        chk({rdv, perr}, 33'h1);
        // start-up order: dead bands, shutdown held, input, controls with enable, release
        wr(`CDG_ADDR_DBR, 32'h3);
        wr(`CDG_ADDR_DBF, 32'h2);
        wr(`CDG_ADDR_SHUT, 32'h80);
        wr(`CDG_ADDR_CTRL1, 32'h22);
        wr(`CDG_ADDR_CTRL0, 32'hF8);
        cyc(3);
        pins(1'b1, 1'b0);
        chk({output_a_oe, output_b_oe}, 2'b11);
        cyc(20);
        pins(1'b1, 1'b0);
        wr(`CDG_ADDR_SHUT, 32'h0);
        cyc(4);
        pins(1'b1, 1'b0);
        edge_run(1'b1, 4, 7);
        edge_run(1'b0, 3, 6);
        wr(`CDG_ADDR_DBR, 32'h0);
        edge_run(1'b1, 1, 4);
        edge_run(1'b0, 3, 6);
        wr(`CDG_ADDR_DBR, 32'h5);
        short_pulse();
        wr(`CDG_ADDR_DBR, 32'h3F);
        edge_run(1'b1, 64, 67);
        edge_run(1'b0, 3, 6);
        chk(shoot_through, 1'b0);
        wr(`CDG_ADDR_CTRL0, 32'hF9);
        chk(fast_osc_request, 1'b1);
        wr(`CDG_ADDR_DBR, 32'h3);
        off_max = 6;
        edge_run(1'b1, 10, 28);
        edge_run(1'b0, 7, 24);
        off_max = 4;
        wr(`CDG_ADDR_CTRL0, 32'hF8);
        chk(fast_osc_request, 1'b0);
        for (int s = 0; s < 4; s++) begin
            wr(`CDG_ADDR_CTRL1, 32'h20 | s);
            cyc(6);
            chk(output_a, 1'b0);
            drv[s] <= 1'b1;
            cyc(10);
            chk(output_a, 1'b1);
            drv[s] <= 1'b0;
            cyc(10);
        end
        wr(`CDG_ADDR_CTRL1, 32'h22);
        for (int c = 0; c < 4; c++) begin
            for (int t = 0; t < 3; t++) begin
                wr(`CDG_ADDR_SHUT, 32'h40 | c);
                drv[(t == 2) ? 4 : t] <= 1'b1;
                cyc(3);
                apb(`CDG_ADDR_SHUT, 1'b0, 32'h0);
                chk(rdv[7], SD_MASK[c * 3 + t]);
                drv <= 5'h00;
                cyc(3);
                apb(`CDG_ADDR_SHUT, 1'b0, 32'h0);
                chk(rdv[7], 1'b0);
            end
        end
        wr(`CDG_ADDR_SHUT, 32'hC0);
        cyc(2);
        apb(`CDG_ADDR_SHUT, 1'b0, 32'h0);
        chk(rdv[7], 1'b0);
        pins(1'b1, 1'b0);
        edge_run(1'b1, 4, 7);
        edge_run(1'b0, 3, 6);
        wr(`CDG_ADDR_SHUT, 32'h0);
        wr(`CDG_ADDR_CTRL0, 32'hF0);
        drv[4] <= 1'b1;
        cyc(3);
        pins(1'b1, 1'b0);
        wr(`CDG_ADDR_SHUT, 32'h0);
        apb(`CDG_ADDR_SHUT, 1'b0, 32'h0);
        chk(rdv[7], 1'b1);
        drv[4] <= 1'b0;
        cyc(3);
        wr(`CDG_ADDR_SHUT, 32'h0);
        apb(`CDG_ADDR_SHUT, 1'b0, 32'h0);
        chk(rdv[7], 1'b0);
        pins(1'b1, 1'b0);
        drv[2] <= 1'b1;
        cyc(12);
        pins(1'b0, 1'b0);
        wr(`CDG_ADDR_CTRL0, 32'hD8);
        cyc(2);
        chk({output_a_oe, output_b_oe}, 2'b01);
        wr(`CDG_ADDR_CTRL0, 32'h0);
        cyc(2);
        chk({output_a_oe, output_b_oe, output_a, output_b}, 4'h0);
        drv[2] <= 1'b0;
        wr(`CDG_ADDR_CTRL0, 32'hF8);
        cyc(1);
        pins(1'b0, 1'b0);
        close_out();
    end

    initial begin
        cyc(20000);
        n_mismatch++;
        close_out();
    end
endmodule
